// ==== mpfc_port.v ====
// per-port flow control, transmit flush and short/runt receive classification
`timescale 1ns/1ps
`include "mpfc_map.vh"
module mpfc_port (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg irq,
    input wire half_duplex,
    input wire fiber_mode,
    input wire rx_fifo_high,
    input wire ext_pause_req,
    input wire tx_frame_valid,
    input wire tx_frame_start,
    input wire tx_frame_end,
    output reg tx_frame_ready,
    output reg tx_frame_drop,
    input wire line_clk,
    input wire rx_dv,
    input wire rx_pause_seen,
    input wire [15:0] rx_pause_time,
    output reg col_force,
    output reg pause_send,
    output reg tx_halt,
    output reg rx_short,
    output reg rx_runt
);
    // line-side inputs other than rx_pause_time cross through two flops
    wire clk_s;
    wire dv_s;
    wire pause_s;
    wire hi_s;
    mpfc_sync u_sync_clk (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .d(line_clk),
        .q(clk_s)
    );
    mpfc_sync u_sync_dv (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .d(rx_dv),
        .q(dv_s)
    );
    mpfc_sync u_sync_pause (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .d(rx_pause_seen),
        .q(pause_s)
    );
    mpfc_sync u_sync_hi (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .d(rx_fifo_high),
        .q(hi_s)
    );

    function is_copper;
        input [2:0] mode;
        begin
            case (mode)
                `MPFC_MODE_GMII: is_copper = 1'b1;
                `MPFC_MODE_RG10: is_copper = 1'b1;
                `MPFC_MODE_RG100: is_copper = 1'b1;
                default: is_copper = (mode[2:1] == 2'b11);
            endcase
        end
    endfunction

    // address match qualified by a strobe
    function reg_hit;
        input [7:0] addr;
        input [7:0] off;
        input strobe;
        begin
            reg_hit = strobe && (addr == off);
        end
    endfunction

    // one-step countdown shared by the collision and pause timers
    function [5:0] dec6;
        input [5:0] v;
        begin
            dec6 = v - 6'h01;
        end
    endfunction

    // length below the programmed short threshold
    function below_thr;
        input [15:0] len;
        input [4:0] limit;
        begin
            below_thr = (len < {11'h000, limit});
        end
    endfunction

    reg [2:0] port_mode;
    reg flush;
    reg [2:0] fc_en;
    reg [5:0] bp_len;
    reg [4:0] thr;
    reg [`MPFC_ST_W-1:0] status;
    reg [`MPFC_ST_W-1:0] mask;
    reg clk_d;
    reg dv_d;
    reg pause_d;
    wire byte_tick = clk_s & ~clk_d;
    wire copper = is_copper(port_mode) & ~fiber_mode;

    // register writes, one enable per register
    wire wr_mode = reg_hit(reg_addr, `MPFC_OFF_MODE, reg_wr);
    wire wr_flush = reg_hit(reg_addr, `MPFC_OFF_FLUSH, reg_wr);
    wire wr_fc = reg_hit(reg_addr, `MPFC_OFF_FC, reg_wr);
    wire wr_bp = reg_hit(reg_addr, `MPFC_OFF_BP, reg_wr);
    wire wr_thr = reg_hit(reg_addr, `MPFC_OFF_THR, reg_wr);
    wire wr_mask = reg_hit(reg_addr, `MPFC_OFF_MASK, reg_wr);
    wire wr_stat = reg_hit(reg_addr, `MPFC_OFF_STAT, reg_wr);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_mode <= `MPFC_RST_MODE;
            flush <= 1'b0;
            fc_en <= `MPFC_RST_FC;
            bp_len <= `MPFC_RST_BP;
            thr <= `MPFC_RST_THR;
            mask <= {`MPFC_ST_W{1'b0}};
        end else if (clk_en) begin
            if (wr_mode) begin
                port_mode <= reg_wdata[2:0];
            end
            if (wr_flush) begin
                flush <= reg_wdata[`MPFC_BIT_FLUSH];
            end
            if (wr_fc) begin
                fc_en <= reg_wdata[2:0];
            end
            if (wr_bp) begin
                bp_len <= reg_wdata[5:0];
            end
            if (wr_thr) begin
                thr <= reg_wdata[4:0];
            end
            if (wr_mask) begin
                mask <= reg_wdata[`MPFC_ST_W-1:0];
            end
        end
    end

    // transmit flush: a frame is dropped if flush was set at its start
    reg in_frame;
    reg drop_frame;
    wire start_drop = tx_frame_valid & tx_frame_start & flush;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_frame <= 1'b0;
            drop_frame <= 1'b0;
            tx_frame_drop <= 1'b0;
            tx_frame_ready <= 1'b0;
        end else if (clk_en) begin
            tx_frame_ready <= ~tx_halt;
            if (tx_frame_valid && tx_frame_start) begin
                in_frame <= ~tx_frame_end;
                drop_frame <= flush;
            end else if (tx_frame_valid && tx_frame_end) begin
                in_frame <= 1'b0;
            end
            // a frame in flight is cut as soon as flush is set
            tx_frame_drop <= start_drop | (in_frame & drop_frame) | (in_frame & flush);
        end
    end

    // back-pressure collision held for bp_len byte ticks unless the link clock stops or duplex changes
    reg [5:0] bp_cnt;
    reg bp_evt;
    reg [7:0] idle_cnt;
    wire bp_start = ~col_force & half_duplex & fc_en[`MPFC_BIT_HDBP] & hi_s & dv_s;
    wire link_idle = (idle_cnt == `MPFC_IDLE_CYCLES);

    // link clock stopped: a collision must not be held forever
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt <= 8'h00;
        end else if (clk_en) begin
            if (byte_tick || bp_start) begin
                idle_cnt <= 8'h00;
            end else if (!link_idle) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            col_force <= 1'b0;
            bp_cnt <= 6'h00;
            bp_evt <= 1'b0;
        end else if (clk_en) begin
            bp_evt <= 1'b0;
            if (bp_start) begin
                col_force <= 1'b1;
                bp_cnt <= bp_len;
                bp_evt <= 1'b1;
            end else if (col_force && (link_idle || !half_duplex)) begin
                // stopped link clock or duplex change ends it early
                col_force <= 1'b0;
            end else if (col_force && byte_tick) begin
                if (bp_cnt <= 6'h01) begin
                    col_force <= 1'b0;
                end else begin
                    bp_cnt <= dec6(bp_cnt);
                end
            end
        end
    end

    // pause generation on rising request
    reg req_d;
    wire req = ~half_duplex & (hi_s | ext_pause_req);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_d <= 1'b0;
            pause_send <= 1'b0;
        end else if (clk_en) begin
            req_d <= req;
            pause_send <= req & ~req_d & fc_en[`MPFC_BIT_PGEN];
        end
    end

    // pause response: quanta of 512 bit times = 64 byte ticks
    reg [15:0] quanta;
    reg [5:0] qbyte;
    reg pause_evt;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            quanta <= 16'h0000;
            qbyte <= 6'h00;
            tx_halt <= 1'b0;
            pause_evt <= 1'b0;
        end else if (clk_en) begin
            pause_evt <= 1'b0;
            if (pause_s && !pause_d && fc_en[`MPFC_BIT_PRSP] && !half_duplex) begin
                quanta <= rx_pause_time;
                qbyte <= `MPFC_QUANTA_BYTES;
                // zero pause time releases at once
                tx_halt <= (rx_pause_time != 16'h0000);
                pause_evt <= 1'b1;
            end else if (tx_halt && byte_tick) begin
                if (qbyte != 6'h00) begin
                    qbyte <= dec6(qbyte);
                end else if (quanta <= 16'h0001) begin
                    tx_halt <= 1'b0;
                    quanta <= 16'h0000;
                end else begin
                    quanta <= quanta - 16'h0001;
                    qbyte <= `MPFC_QUANTA_BYTES;
                end
            end
        end
    end

    // receive length count and classification at end of frame
    reg [15:0] rx_len;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_d <= 1'b0;
            dv_d <= 1'b0;
            pause_d <= 1'b0;
            rx_len <= 16'h0000;
            rx_short <= 1'b0;
            rx_runt <= 1'b0;
        end else if (clk_en) begin
            clk_d <= clk_s;
            pause_d <= pause_s;
            rx_short <= 1'b0;
            rx_runt <= 1'b0;
            if (byte_tick) begin
                dv_d <= dv_s;
                // length saturates so a long frame never wraps into runt range
                if (dv_s && !dv_d) begin
                    rx_len <= 16'h0001;
                end else if (dv_s && rx_len != 16'hFFFF) begin
                    rx_len <= rx_len + 16'h0001;
                end
                if (!dv_s && dv_d && copper) begin
                    rx_short <= below_thr(rx_len, thr);
                    rx_runt <= !below_thr(rx_len, thr) &&
                        (rx_len < `MPFC_RUNT_LIMIT);
                end
            end
        end
    end

    // sticky status, set wins over write-one clear
    wire [`MPFC_ST_W-1:0] ev = {tx_frame_drop, bp_evt, pause_evt, rx_runt, rx_short};
    wire [`MPFC_ST_W-1:0] next_status =
        (status & ~(wr_stat ? reg_wdata[`MPFC_ST_W-1:0] : {`MPFC_ST_W{1'b0}})) | ev;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= {`MPFC_ST_W{1'b0}};
            irq <= 1'b0;
        end else if (clk_en) begin
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end

    // read data one cycle after strobe
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            `MPFC_OFF_MODE: next_rdata = {29'h0000_0000, port_mode};
            `MPFC_OFF_FLUSH: next_rdata = {31'h0000_0000, flush};
            `MPFC_OFF_FC: next_rdata = {29'h0000_0000, fc_en};
            `MPFC_OFF_BP: next_rdata = {26'h000_0000, bp_len};
            `MPFC_OFF_THR: next_rdata = {27'h000_0000, thr};
            `MPFC_OFF_STAT: next_rdata = {27'h000_0000, status};
            `MPFC_OFF_MASK: next_rdata = {27'h000_0000, mask};
            // live state view, read only
            `MPFC_OFF_STATE: next_rdata = {28'h000_0000, copper, tx_halt, col_force, in_frame};
            default: next_rdata = 32'h0000_0000;
        endcase
    end
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end
endmodule // mpfc_port

// ==== mpfc_map.vh ====
// register map, field positions, reset values and timing counts for the port flow-control block
// How it works
// - While the flush bit 0 is set, frames offered for transmit are dropped and nothing goes out.
// - In half duplex with back-pressure enable bit 2 set and receive fill above the high mark, a collision is forced on the incoming frame.
// - With pause generate bit 1 set, pause frames are requested in full duplex from the watermark or the external pause input; with it clear, none.
// - With pause respond bit 0 set, transmit halts in full duplex for the received pause time; with it clear, received pauses are ignored.
// - After reset the flow-control enable register reads 0x7, all three modes on.
// - Each forced collision lasts the 6-bit duration in bits 5:0 in byte cycles, default 12, unless the link clock stops or duplex changes first.
// - A received frame shorter than the 5-bit threshold in bits 4:0, default 8, is flagged short.
// - A received frame at or above the threshold but under 64 bytes is flagged runt.
// - Short and runt flagging works only when the port mode is GMII or RGMII copper.
// - Port mode 010 is GMII 1000, 100 and 101 are RGMII 10 and 100, 11x is RGMII 1000.
`ifndef MPFC_MAP_VH
`define MPFC_MAP_VH
`define MPFC_ADDR_W 8
`define MPFC_OFF_MODE 8'h10
`define MPFC_OFF_FLUSH 8'h11
`define MPFC_OFF_FC 8'h12
`define MPFC_OFF_BP 8'h13
`define MPFC_OFF_THR 8'h14
`define MPFC_OFF_STAT 8'h20
`define MPFC_OFF_MASK 8'h21
`define MPFC_OFF_STATE 8'h22
`define MPFC_RST_MODE 3'h2
`define MPFC_RST_FC 3'h7
`define MPFC_RST_BP 6'h0C
`define MPFC_RST_THR 5'h08
`define MPFC_BIT_FLUSH 0
`define MPFC_BIT_HDBP 2
`define MPFC_BIT_PGEN 1
`define MPFC_BIT_PRSP 0
`define MPFC_RUNT_LIMIT 16'h0040
`define MPFC_MODE_GMII 3'h2
`define MPFC_MODE_RG10 3'h4
`define MPFC_MODE_RG100 3'h5
`define MPFC_QUANTA_BYTES 6'h3F
`define MPFC_IDLE_CYCLES 8'h40
`define MPFC_ST_SHORT 0
`define MPFC_ST_RUNT 1
`define MPFC_ST_PAUSE 2
`define MPFC_ST_BP 3
`define MPFC_ST_DROP 4
`define MPFC_ST_W 5
`endif

// ==== mpfc_sync.v ====
// two-flop synchroniser for one level
`timescale 1ns/1ps
module mpfc_sync (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire d,
    output reg q
);
    reg meta;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else if (clk_en) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // mpfc_sync

// ==== mpfc_port_sva.sv ====
// concurrent checks on the port flow-control block
`timescale 1ns/1ps
module mpfc_port_sva (
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire half_duplex,
    input wire fiber_mode,
    input wire tx_frame_ready,
    input wire col_force,
    input wire pause_send,
    input wire tx_halt,
    input wire rx_short,
    input wire rx_runt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n || !clk_en);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    a_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) >= 8'h11 &&
        $past(reg_addr) <= 8'h14 |-> reg_rdata[31:6] == 26'h000_0000)
        else $error("reserved bits not zero");
    a_class_excl: assert property (!(rx_short && rx_runt))
        else $error("short and runt together");
    a_fiber_quiet: assert property ($past(fiber_mode) |-> !rx_short && !rx_runt)
        else $error("classification in fiber mode");
    a_pause_pulse: assert property (pause_send |=> !pause_send)
        else $error("pause request longer than one cycle");
    a_halt_stall: assert property (tx_halt |=> !tx_frame_ready)
        else $error("ready while halted");
    a_col_half: assert property ($rose(col_force) |-> $past(half_duplex))
        else $error("collision in full duplex");
    a_col_min: assert property ($rose(col_force) |-> col_force [*8])
        else $error("collision too short");
endmodule // mpfc_port_sva

bind mpfc_port mpfc_port_sva chk_u (.*);

// ==== mpfc_phy_model.sv ====
// copper phy model: receive frames and pause indications
`timescale 1ns/1ps
module mpfc_phy_model (
    output reg line_clk,
    output reg rx_dv,
    output reg rx_pause_seen,
    output reg [15:0] rx_pause_time
);
    integer k;
    initial begin
        line_clk = 1'b0;
        rx_dv = 1'b0;
        rx_pause_seen = 1'b0;
        rx_pause_time = 16'h0000;
    end
    // link clock runs only inside frames, plus a few closing ticks
    task send_frame(input integer len);
        begin
            rx_dv = 1'b1;
            for (k = 0; k < len + 3; k = k + 1) begin
                #32 line_clk = 1'b1;
                #32 line_clk = 1'b0;
                if (k == len - 1) rx_dv = 1'b0;
            end
        end
    endtask
    task send_pause(input [15:0] t);
        begin
            rx_pause_time = t;
            #20 rx_pause_seen = 1'b1;
            #100 rx_pause_seen = 1'b0;
            // pause time no longer held
            #20 rx_pause_time = ~t;
        end
    endtask
endmodule // mpfc_phy_model

// ==== mpfc_port_tb.sv ====
// bench for the port flow-control block
`timescale 1ns/1ps
module mpfc_port_tb;
    reg sys_clk = 0, reset_n = 0, clk_en = 1, half_duplex = 0, fiber_mode = 0;
    reg rx_fifo_high = 0, ext_pause_req = 0, reg_wr = 0, reg_rd = 0;
    reg tx_frame_valid = 0, tx_frame_start = 0, tx_frame_end = 0;
    reg [7:0] reg_addr = 0;
    reg [31:0] reg_wdata = 0;
    wire [31:0] reg_rdata;
    wire [15:0] rx_pause_time;
    wire irq, tx_frame_ready, tx_frame_drop, line_clk, rx_dv, rx_pause_seen;
    wire col_force, pause_send, tx_halt, rx_short, rx_runt;
    integer fails = 0, tests_run = 0, npause = 0, i;
    integer lens [0:3] = '{7, 8, 63, 64};
    mpfc_port dut_u (.*);
    mpfc_phy_model phy_u (.*);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) npause <= npause + pause_send;
    task report_and_stop;
        begin
            if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, e);
        end
    endtask
    task frame_chk(input integer len, input [31:0] e);
        begin
            phy_u.send_frame(len);
            repeat (8) @(posedge sys_clk);
            chk(irq, e != 0);
            rchk(8'h20, e);
            wr(8'h20, 32'h0000_001f);
        end
    endtask
    task tx_frame;
        begin
            @(posedge sys_clk);
            tx_frame_valid <= 1'b1;
            tx_frame_start <= 1'b1;
            @(posedge sys_clk);
            tx_frame_start <= 1'b0;
            tx_frame_end <= 1'b1;
            @(posedge sys_clk);
            tx_frame_valid <= 1'b0;
            tx_frame_end <= 1'b0;
        end
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(8'h11, 32'h0000_0000);
        rchk(8'h12, 32'h0000_0007);
        rchk(8'h13, 32'h0000_000c);
        rchk(8'h14, 32'h0000_0008);
        rchk(8'h30, 32'h0000_0000);
        wr(8'h13, 32'hffff_ffff);
        rchk(8'h13, 32'h0000_003f);
        wr(8'h14, 32'hffff_ffff);
        rchk(8'h14, 32'h0000_001f);
        wr(8'h14, 32'h0000_0008);
        wr(8'h13, 32'h0000_000c);
        wr(8'h21, 32'h0000_0003);
        for (i = 0; i < 4; i = i + 1) begin
            frame_chk(lens[i], lens[i] < 8 ? 1 : (lens[i] < 64 ? 2 : 0));
        end
        fiber_mode <= 1'b1;
        frame_chk(7, 0);
        fiber_mode <= 1'b0;
        wr(8'h10, 32'h0000_0000);
        frame_chk(7, 0);
        for (i = 4; i < 8; i = i + 1) begin
            wr(8'h10, i);
            frame_chk(7, 1);
        end
        phy_u.send_pause(16'h0001);
        repeat (10) @(posedge sys_clk);
        chk(tx_halt, 1);
        chk(tx_frame_ready, 0);
        phy_u.send_frame(100);
        chk(tx_halt, 0);
        wr(8'h12, 32'h0000_0006);
        phy_u.send_pause(16'h0001);
        repeat (10) @(posedge sys_clk);
        chk(tx_halt, 0);
        ext_pause_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(npause, 1);
        ext_pause_req <= 1'b0;
        wr(8'h12, 32'h0000_0005);
        ext_pause_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(npause, 1);
        ext_pause_req <= 1'b0;
        wr(8'h12, 32'h0000_0007);
        rx_fifo_high <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(npause, 2);
        half_duplex <= 1'b1;
        wr(8'h20, 32'h0000_001f);
        phy_u.send_frame(70);
        rchk(8'h20, 32'h0000_0008);
        wr(8'h12, 32'h0000_0003);
        wr(8'h20, 32'h0000_001f);
        phy_u.send_frame(70);
        rchk(8'h20, 32'h0000_0000);
        wr(8'h11, 32'hffff_ffff);
        rchk(8'h11, 32'h0000_0001);
        tx_frame;
        rchk(8'h20, 32'h0000_0010);
        wr(8'h11, 32'h0000_0000);
        wr(8'h20, 32'h0000_001f);
        tx_frame;
        rchk(8'h20, 32'h0000_0000);
        report_and_stop;
    end
endmodule // mpfc_port_tb
